// ==== rtl/pss_pkg.sv ====
package pss_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] PSS_OFF_CTRL    = 8'h00;
   localparam logic [7:0] PSS_OFF_WAKE_LO = 8'h04;
   localparam logic [7:0] PSS_OFF_WAKE_HI = 8'h08;
   localparam logic [7:0] PSS_OFF_SLEEP   = 8'h0c;
   localparam logic [7:0] PSS_OFF_ROUSE1  = 8'h10;
   localparam logic [7:0] PSS_OFF_ROUSE2  = 8'h14;
   // ==========================================================
   // general control fields
   localparam int PSS_CTL_CLKSEL = 0;
   localparam int PSS_CTL_SLEEP  = 1;
   localparam int PSS_CTL_PINEN  = 2;
   localparam int PSS_CTL_PINPOL = 3;
   localparam int PSS_CTL_TIMEN  = 4;
   localparam int PSS_CTL_WIDE   = 5;
   localparam logic [5:0] PSS_CTL_RESET = 6'h08;
   localparam logic [5:0] PSS_CTL_WMASK = 6'h3d;
   // ==========================================================
   // state register fields
   localparam int PSS_DWELL_LSB = 16;
   localparam int PSS_GATE_BIT  = 14;
   localparam int PSS_APFM_BIT  = 9;
   localparam int PSS_CPFM_BIT  = 8;
   localparam int PSS_IO_BIT    = 5;
   localparam int PSS_PLL_BIT   = 4;
   localparam int PSS_AEN_BIT   = 1;
   localparam int PSS_CEN_BIT   = 0;
   localparam logic [31:0] PSS_CFG_WMASK  = 32'h001f4331;
   localparam logic [31:0] PSS_SLEEP_INIT = 32'h00100000;
   localparam logic [31:0] PSS_ROUSE1_INIT = 32'h00100020;
   localparam logic [31:0] PSS_ROUSE2_INIT = 32'h00100031;
   localparam logic [31:0] PSS_RUN_CFG    = 32'h00000033;
   localparam logic [2:0]  PSS_AEN_RO     = 3'h4;
   // ==========================================================
   // types
   typedef enum logic [3:0] {
      PSS_RUNNING = 4'h1,
      PSS_SLEEP   = 4'h2,
      PSS_ROUSE1  = 4'h4,
      PSS_ROUSE2  = 4'h8
   } pss_fsm_type;

   typedef struct packed {
      pss_fsm_type      fsm;
      logic [31:0]      cnt;
      logic [5:0]       ctrl;
      logic [31:0]      wlo;
      logic [31:0]      whi;
      logic [2:0][31:0] cfg;
      logic [31:0]      rdata;
      logic             core_en;
      logic             ana_en;
      logic             core_pfm;
      logic             ana_pfm;
      logic             io_en;
      logic             pll_en;
      logic             clk_gate;
      logic             pin_m;
      logic             pin_s;
      logic [3:0]       good_m;
      logic [3:0]       good_s;
   } pss_state_type;
endpackage : pss_pkg

// ==== rtl/pss_sequencer.sv ====
`timescale 1ns/1ps
module pss_sequencer
   import pss_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   input  wire logic              i_clk,
   input  wire logic              i_reset,
   input  wire logic              i_reg_wr,
   input  wire logic              i_reg_rd,
   input  wire logic [ADDR_W-1:0] i_reg_addr,
   input  wire logic [31:0]       i_reg_wdata,
   output logic      [31:0]       o_reg_rdata,
   input  wire logic [63:0]       i_rtc_count,
   input  wire logic              i_wake_pin,
   input  wire logic [3:0]        i_supply_good,
   output logic      [3:0]        o_state,
   output logic                   o_core_conv_en,
   output logic                   o_analog_conv_en,
   output logic                   o_core_conv_pfm,
   output logic                   o_analog_conv_pfm,
   output logic                   o_io_supply_en,
   output logic                   o_pll_reg_en,
   output logic                   o_tile_clk_gate
);
   // ==========================================================
   // elaboration check
   if (ADDR_W < 8)
   begin : g_bad_addr
      $error("address width too small for register map");
   end

   pss_state_type q;
   pss_state_type d;

   logic [7:0]  addr;
   logic [1:0]  idx;
   logic [31:0] cur_cfg;
   logic [31:0] dwell_mask;
   logic        dwell_done;
   logic        timer_hit;
   logic        pin_hit;
   logic [3:0]  need;
   logic        supplies_ok;
   logic [31:0] nxt_cfg;

   assign addr = i_reg_addr[7:0];

   // ==========================================================
   // next state
   always_comb
   begin
      d = q;
      // current state register view
      idx = 2'd0;
      if (q.fsm == PSS_ROUSE1)
      begin
         idx = 2'd1;
      end
      else if (q.fsm == PSS_ROUSE2)
      begin
         idx = 2'd2;
      end
      cur_cfg = q.cfg[idx];
      cur_cfg[PSS_AEN_BIT] = PSS_AEN_RO[idx];
      // dwell of 2**n cycles on the running clock
      dwell_mask = (32'h1 << cur_cfg[PSS_DWELL_LSB +: 5]) - 32'h1;
      dwell_done = (q.cnt >= dwell_mask);
      // wake sources
      if (q.ctrl[PSS_CTL_WIDE] && q.fsm == PSS_SLEEP)
      begin
         timer_hit = q.ctrl[PSS_CTL_TIMEN] && (i_rtc_count == {q.whi, q.wlo});
      end
      else
      begin
         timer_hit = q.ctrl[PSS_CTL_TIMEN] && (i_rtc_count[31:0] == q.wlo);
      end
      pin_hit = q.ctrl[PSS_CTL_PINEN] && (q.pin_s == q.ctrl[PSS_CTL_PINPOL]);
      // supplies: {io, pll, analogue, core}
      need = {cur_cfg[PSS_IO_BIT], cur_cfg[PSS_PLL_BIT],
              cur_cfg[PSS_AEN_BIT], cur_cfg[PSS_CEN_BIT]};
      supplies_ok = ((need & q.good_s) == need);

      // synchronisers
      d.pin_m  = i_wake_pin;
      d.pin_s  = q.pin_m;
      d.good_m = i_supply_good;
      d.good_s = q.good_m;

      // dwell counter, saturates once the minimum is met
      if (!dwell_done)
      begin
         d.cnt = q.cnt + 32'h1;
      end

      // register writes
      if (i_reg_wr)
      begin
         if (addr == PSS_OFF_CTRL)
         begin
            d.ctrl = i_reg_wdata[5:0] & PSS_CTL_WMASK;
         end
         else if (addr == PSS_OFF_WAKE_LO)
         begin
            d.wlo = i_reg_wdata;
         end
         else if (addr == PSS_OFF_WAKE_HI)
         begin
            d.whi = i_reg_wdata;
         end
         else if (addr == PSS_OFF_SLEEP)
         begin
            d.cfg[0] = i_reg_wdata & PSS_CFG_WMASK;
         end
         else if (addr == PSS_OFF_ROUSE1)
         begin
            d.cfg[1] = i_reg_wdata & PSS_CFG_WMASK;
         end
         else if (addr == PSS_OFF_ROUSE2)
         begin
            d.cfg[2] = i_reg_wdata & PSS_CFG_WMASK;
         end
      end

      // sequencer
      case (q.fsm)
         PSS_RUNNING:
         begin
            // sleep request is a self-clearing write of control bit 1
            if (i_reg_wr && addr == PSS_OFF_CTRL && i_reg_wdata[PSS_CTL_SLEEP])
            begin
               d.fsm = PSS_SLEEP;
            end
         end
         PSS_SLEEP:
         begin
            if (dwell_done && (timer_hit || pin_hit))
            begin
               d.fsm = PSS_ROUSE1;
            end
         end
         PSS_ROUSE1:
         begin
            if (dwell_done && supplies_ok)
            begin
               d.fsm = PSS_ROUSE2;
            end
         end
         PSS_ROUSE2:
         begin
            if (dwell_done && supplies_ok)
            begin
               d.fsm = PSS_RUNNING;
            end
         end
         default:
         begin
            d.fsm = PSS_RUNNING;
         end
      endcase
      if (d.fsm != q.fsm)
      begin
         d.cnt = 32'h0;
      end

      // supply controls follow the state being entered
      nxt_cfg = PSS_RUN_CFG;
      if (d.fsm == PSS_SLEEP)
      begin
         nxt_cfg = d.cfg[0];
         nxt_cfg[PSS_AEN_BIT] = PSS_AEN_RO[0];
      end
      else if (d.fsm == PSS_ROUSE1)
      begin
         nxt_cfg = d.cfg[1];
         nxt_cfg[PSS_AEN_BIT] = PSS_AEN_RO[1];
      end
      else if (d.fsm == PSS_ROUSE2)
      begin
         nxt_cfg = d.cfg[2];
         nxt_cfg[PSS_AEN_BIT] = PSS_AEN_RO[2];
      end
      d.clk_gate = nxt_cfg[PSS_GATE_BIT];
      d.ana_pfm  = nxt_cfg[PSS_APFM_BIT];
      d.core_pfm = nxt_cfg[PSS_CPFM_BIT];
      d.io_en    = nxt_cfg[PSS_IO_BIT];
      d.pll_en   = nxt_cfg[PSS_PLL_BIT];
      d.ana_en   = nxt_cfg[PSS_AEN_BIT];
      d.core_en  = nxt_cfg[PSS_CEN_BIT];

      // register reads, unmapped offsets read zero
      if (i_reg_rd)
      begin
         if (addr == PSS_OFF_CTRL)
         begin
            d.rdata = {26'h0, q.ctrl};
         end
         else if (addr == PSS_OFF_WAKE_LO)
         begin
            d.rdata = q.wlo;
         end
         else if (addr == PSS_OFF_WAKE_HI)
         begin
            d.rdata = q.whi;
         end
         else if (addr == PSS_OFF_SLEEP)
         begin
            d.rdata = q.cfg[0] | {30'h0, PSS_AEN_RO[0], 1'b0};
         end
         else if (addr == PSS_OFF_ROUSE1)
         begin
            d.rdata = q.cfg[1] | {30'h0, PSS_AEN_RO[1], 1'b0};
         end
         else if (addr == PSS_OFF_ROUSE2)
         begin
            d.rdata = q.cfg[2] | {30'h0, PSS_AEN_RO[2], 1'b0};
         end
         else
         begin
            d.rdata = 32'h0;
         end
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         q          <= '0;
         q.fsm      <= PSS_RUNNING;
         q.ctrl     <= PSS_CTL_RESET;
         q.cfg[0]   <= PSS_SLEEP_INIT;
         q.cfg[1]   <= PSS_ROUSE1_INIT;
         q.cfg[2]   <= PSS_ROUSE2_INIT;
         q.core_en  <= PSS_RUN_CFG[PSS_CEN_BIT];
         q.ana_en   <= PSS_RUN_CFG[PSS_AEN_BIT];
         q.io_en    <= PSS_RUN_CFG[PSS_IO_BIT];
         q.pll_en   <= PSS_RUN_CFG[PSS_PLL_BIT];
      end
      else
      begin
         q <= d;
      end
   end

   assign o_reg_rdata       = q.rdata;
   assign o_state           = q.fsm;
   assign o_core_conv_en    = q.core_en;
   assign o_analog_conv_en  = q.ana_en;
   assign o_core_conv_pfm   = q.core_pfm;
   assign o_analog_conv_pfm = q.ana_pfm;
   assign o_io_supply_en    = q.io_en;
   assign o_pll_reg_en      = q.pll_en;
   assign o_tile_clk_gate   = q.clk_gate;

   // ==========================================================
   // checks
   narrow_compare_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (q.fsm == PSS_SLEEP && dwell_done && q.ctrl[PSS_CTL_TIMEN] && !q.ctrl[PSS_CTL_WIDE]
       && i_rtc_count[31:0] == q.wlo) |=> (q.fsm == PSS_ROUSE1))
      else $error("32-bit timer match did not wake");

   wide_compare_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (q.fsm == PSS_SLEEP && q.ctrl[PSS_CTL_WIDE] && !pin_hit
       && i_rtc_count[63:32] != q.whi) |=> (q.fsm == PSS_SLEEP))
      else $error("64-bit mode woke on upper word mismatch");

   upper_readback_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_reg_wr && addr == PSS_OFF_WAKE_HI ##1 i_reg_rd && !i_reg_wr
       && addr == PSS_OFF_WAKE_HI) |=> (o_reg_rdata == $past(i_reg_wdata, 2)))
      else $error("upper wake word readback wrong");

   sleep_dwell_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (q.fsm == PSS_SLEEP && !dwell_done) |=> (q.fsm == PSS_SLEEP))
      else $error("left sleep before dwell expired");

   no_source_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (q.fsm == PSS_SLEEP && !q.ctrl[PSS_CTL_TIMEN] && !q.ctrl[PSS_CTL_PINEN])
      |=> (q.fsm == PSS_SLEEP))
      else $error("woke with both sources disabled");

   pin_wake_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (q.fsm == PSS_SLEEP && dwell_done && q.ctrl[PSS_CTL_PINEN]
       && q.pin_s == q.ctrl[PSS_CTL_PINPOL]) |=> (q.fsm == PSS_ROUSE1))
      else $error("pin wake level ignored");

   supply_wait_a: assert property (@(posedge i_clk) disable iff (i_reset)
      ((q.fsm == PSS_ROUSE1 || q.fsm == PSS_ROUSE2) && !supplies_ok)
      |=> (q.fsm == $past(q.fsm)))
      else $error("rousing state left with a supply not good");

   dwell_length_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (q.fsm != PSS_RUNNING && d.fsm != q.fsm) |-> (q.cnt >= dwell_mask))
      else $error("state left before 2**n cycles");

   clock_gate_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (q.fsm == PSS_SLEEP) |-> (o_tile_clk_gate == q.cfg[0][PSS_GATE_BIT]))
      else $error("tile clock gate not per sleep register");

   modulation_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (q.fsm == PSS_ROUSE1) |-> (o_analog_conv_pfm == q.cfg[1][PSS_APFM_BIT]
       && o_core_conv_pfm == q.cfg[1][PSS_CPFM_BIT]))
      else $error("modulation not per rousing register");

   enables_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (q.fsm == PSS_ROUSE2) |-> (o_io_supply_en == q.cfg[2][PSS_IO_BIT]
       && o_pll_reg_en == q.cfg[2][PSS_PLL_BIT] && o_core_conv_en == q.cfg[2][PSS_CEN_BIT]
       && o_analog_conv_en))
      else $error("supply enables not per second rousing register");

   ro_bit_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_reg_rd && (addr == PSS_OFF_SLEEP || addr == PSS_OFF_ROUSE1))
      |=> !o_reg_rdata[PSS_AEN_BIT])
      else $error("read-only analogue enable reads one");

   reserved_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_reg_rd && (addr == PSS_OFF_SLEEP || addr == PSS_OFF_ROUSE2))
      |=> ((o_reg_rdata & ~(PSS_CFG_WMASK | 32'h2)) == 32'h0))
      else $error("reserved bits read nonzero");

   order_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (q.fsm != $past(q.fsm)) |-> (($past(q.fsm) == PSS_SLEEP && q.fsm == PSS_ROUSE1)
       || ($past(q.fsm) == PSS_ROUSE1 && q.fsm == PSS_ROUSE2)
       || ($past(q.fsm) == PSS_ROUSE2 && q.fsm == PSS_RUNNING)
       || ($past(q.fsm) == PSS_RUNNING && q.fsm == PSS_SLEEP)))
      else $error("illegal sequencer step");
endmodule : pss_sequencer

// ==== testbench/pss_supply_model.sv ====
`timescale 1ns/1ps
// ==========================================
// regulators: each good rises a settle time after its enable
module pss_supply_model (
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   input  wire logic [3:0] i_en,
   input  wire logic [3:0] i_settle,
   output logic      [3:0] o_good
);
   logic [3:0] age [4];
   always @(posedge i_clk or posedge i_reset)
      for (int k = 0; k < 4; k++)
         if (i_reset || !i_en[k])
            age[k] <= 4'h0;
         else if (age[k] < i_settle)
            age[k] <= age[k] + 4'h1;
   // a disabled supply never reports good
   always_comb
      for (int k = 0; k < 4; k++)
         o_good[k] = i_en[k] && age[k] >= i_settle;
endmodule : pss_supply_model

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
// ==========================================
// sequencer bench: register model in the bench, regulators beside it
module testbench;
   import pss_pkg::*;
   logic        i_clk   = 1'b0;
   logic        i_reset = 1'b1;
   logic        rd      = 1'b0;
   logic        wr      = 1'b0;
   logic        pin     = 1'b0;
   logic [7:0]  addr    = 8'h00;
   logic [31:0] wdata   = 32'h0;
   logic [63:0] rtc     = 64'h0;
   logic [3:0]  settle  = 4'h2;
   logic [31:0] rdata;
   logic [3:0]  good;
   logic [3:0]  st;
   wire  [6:0]  outs;
   int          fails     = 0;
   int          tests_run = 0;
   int          seed      = 32'hd8c72b42;
   logic [31:0] m [6] = '{32'h8, 32'h0, 32'h0, 32'h00100000, 32'h00100020, 32'h00100033};
   logic [7:0]  tct [7] = '{8'h0e, 8'h06, 8'h12, 8'h32, 8'h3e, 8'h1a, 8'h0e};
   int          thi [7] = '{0, 0, 1, 0, 1, 0, 0};
   int          tpat [7] = '{12, 12, 999, 999, 40, 5, 1};
   int          tlo [7] = '{12, 12, 15, 15, 40, 15, 1};

   pss_sequencer uut (
      .i_clk(i_clk), .i_reset(i_reset), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_rtc_count(rtc), .i_wake_pin(pin), .i_supply_good(good), .o_state(st),
      .o_core_conv_en(outs[0]), .o_analog_conv_en(outs[1]), .o_pll_reg_en(outs[2]),
      .o_io_supply_en(outs[3]), .o_core_conv_pfm(outs[4]), .o_analog_conv_pfm(outs[5]),
      .o_tile_clk_gate(outs[6]));

   pss_supply_model sup (
      .i_clk(i_clk), .i_reset(i_reset), .i_en(outs[3:0]), .i_settle(settle),
      .o_good(good));

   initial
      forever #20 i_clk = ~i_clk;

   always @(posedge i_clk)
      rtc <= #1 rtc + 64'h1;

   // ==========================================
   // reference model
   function automatic int ix(input logic [3:0] s);
      return (s == 4'h2) ? 3 : (s == 4'h4) ? 4 : 5;
   endfunction : ix

   function automatic logic [6:0] expo(input logic [3:0] s);
      logic [31:0] x;
      x = (s == 4'h1) ? 32'h33 : m[ix(s)];
      return {x[14], x[9:8], x[5:4], x[1:0]};
   endfunction : expo

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask : chk

   task automatic stop_test();
      $display("counts: %0d checks, %0d mismatches", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test

   // ==========================================
   // register bus
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      #1 wr = 1'b1;
      addr = a;
      wdata = d;
      if (a < 8'h18)
         m[a[4:2]] = d & ((a == 0) ? 32'h3d : (a < 8'h0c) ? '1 : 32'h001f4331)
                     | ((a == 8'h14) ? 32'h2 : 32'h0);
      @(posedge i_clk);
      #1 wr = 1'b0;
   endtask : wreg

   // write, then read the same word on the very next cycle
   task automatic wrrd(input logic [7:0] a, input logic [31:0] d);
      wreg(a, d);
      rd = 1'b1;
      @(posedge i_clk);
      #1 rd = 1'b0;
      chk("readback", m[a[4:2]], rdata);
   endtask : wrrd

   task automatic rchk(input logic [7:0] a);
      @(posedge i_clk);
      #1 rd = 1'b1;
      addr = a;
      @(posedge i_clk);
      #1 rd = 1'b0;
      chk("rdata", (a < 8'h18) ? m[a[4:2]] : 32'h0, rdata);
   endtask : rchk

   // ==========================================
   // one sleep and wake walk
   task automatic wake(input int t);
      int sc;
      int c;
      int hi;
      logic [3:0] prv;
      logic [3:0] gp;
      settle = 4'($random(seed) & 7);
      // pattern below 2: wake level already present when sleep is entered
      pin = (tpat[t] < 2) ? tct[t][3] : ~tct[t][3];
      for (int k = 3; k < 6; k++)
         wreg(8'(k * 4), $random(seed) & 32'h0003ffff);
      wreg(8'h08, 32'(thi[t]));
      wreg(8'h04, rtc[31:0] + 32'd19);
      wreg(8'h00, 32'(tct[t]));
      prv = 4'h2;
      sc = 1;
      for (c = 0; c < 400; c++)
      begin
         @(posedge i_clk);
         #1;
         chk("outputs", 32'(expo(st)), 32'(outs));
         if (st !== prv)
         begin
            chk("state order", {prv[2:0], prv[3]}, st);
            chk("dwell", 1, sc >= (1 << m[ix(prv)][20:16]));
            hi = (1 << m[ix(prv)][20:16]);
            hi = ((hi > tlo[t]) ? hi : tlo[t]) + 6;
            if (prv == 4'h2)
               chk("wake time", 1, sc >= tlo[t] - 3 && sc <= hi);
            else
               chk("supplies", 32'(expo(prv) & 4'hf), 32'(gp & expo(prv)));
            sc = 1;
            if (st === 4'h1)
               break;
         end
         else
            sc++;
         if (prv == 4'h2 && sc == tpat[t])
            pin = tct[t][3];
         gp = good;
         prv = st;
      end
      if (c == 400)
      begin
         $display("mismatch state walk expected %h seen %h", 4'h1, st);
         fails++;
         stop_test();
      end
   endtask : wake

   initial
   begin
      repeat (4) @(posedge i_clk);
      #1 i_reset = 1'b0;
      chk("outputs", 32'(expo(4'h1)), 32'(outs));
      for (int a = 0; a < 32; a += 4)
         rchk(8'(a));
      $display("test reset values done");
      for (int a = 4; a < 32; a += 4)
         wreg(8'(a), $random(seed));
      for (int a = 0; a < 32; a += 4)
         rchk(8'(a));
      wrrd(8'h08, $random(seed));
      $display("test register access done");
      for (int t = 0; t < 7; t++)
         wake(t);
      $display("test wake walks done");
      stop_test();
   end
endmodule : testbench
